// ### jtv_fsm.v
// Next-state logic of the sixteen-state test controller
`timescale 1ns/1ps
`default_nettype none
`include "jtv_regs.vh"

module jtv_fsm
(
   input wire [3:0] state,
   input wire tms,
   output reg [3:0] next_state
);

   always @*
   begin
      case (state)
         `JTV_ST_RESET: next_state = tms ? `JTV_ST_RESET : `JTV_ST_IDLE;
         `JTV_ST_IDLE: next_state = tms ? `JTV_ST_SEL_DR : `JTV_ST_IDLE;
         `JTV_ST_SEL_DR: next_state = tms ? `JTV_ST_SEL_IR : `JTV_ST_CAP_DR;
         `JTV_ST_CAP_DR: next_state = tms ? `JTV_ST_EXIT1_DR : `JTV_ST_SHIFT_DR;
         `JTV_ST_SHIFT_DR: next_state = tms ? `JTV_ST_EXIT1_DR : `JTV_ST_SHIFT_DR;
         `JTV_ST_EXIT1_DR: next_state = tms ? `JTV_ST_UPD_DR : `JTV_ST_PAUSE_DR;
         `JTV_ST_PAUSE_DR: next_state = tms ? `JTV_ST_EXIT2_DR : `JTV_ST_PAUSE_DR;
         `JTV_ST_EXIT2_DR: next_state = tms ? `JTV_ST_UPD_DR : `JTV_ST_SHIFT_DR;
         `JTV_ST_UPD_DR: next_state = tms ? `JTV_ST_SEL_DR : `JTV_ST_IDLE;
         `JTV_ST_SEL_IR: next_state = tms ? `JTV_ST_RESET : `JTV_ST_CAP_IR;
         `JTV_ST_CAP_IR: next_state = tms ? `JTV_ST_EXIT1_IR : `JTV_ST_SHIFT_IR;
         `JTV_ST_SHIFT_IR: next_state = tms ? `JTV_ST_EXIT1_IR : `JTV_ST_SHIFT_IR;
         `JTV_ST_EXIT1_IR: next_state = tms ? `JTV_ST_UPD_IR : `JTV_ST_PAUSE_IR;
         `JTV_ST_PAUSE_IR: next_state = tms ? `JTV_ST_EXIT2_IR : `JTV_ST_PAUSE_IR;
         `JTV_ST_EXIT2_IR: next_state = tms ? `JTV_ST_UPD_IR : `JTV_ST_SHIFT_IR;
         `JTV_ST_UPD_IR: next_state = tms ? `JTV_ST_SEL_DR : `JTV_ST_IDLE;
         default: next_state = `JTV_ST_RESET;
      endcase
   end

endmodule

`default_nettype wire

// ### jtv_host.sv
// Board test controller model that drives the serial test port
`timescale 1ns/1ps
`default_nettype none

module jtv_host
(
   input wire logic ref_clk,
   input wire logic tdo,
   input wire logic tdo_oe,
   output logic tck,
   output logic tms,
   output logic tdi
);
   // Test clock stands low between frames; idle lines rest at the pull-up level
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // One 160 ns test clock; the output is taken just before the rise, as a real master does
   task automatic step(input logic m, input logic d, output logic o, output logic oe);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge ref_clk);
      // A released line reads inverted, so a missing enable shows up as bad data
      o = tdo_oe ? tdo : ~tdo;
      oe = tdo_oe;
      tck <= 1'b1;
      repeat (16) @(posedge ref_clk);
      tck <= 1'b0;
      repeat (12) @(posedge ref_clk);
   endtask

   // Mode-select string, first bit in bit 0
   task automatic walk(input logic [7:0] path, input int n);
      logic o, oe;
      for (int i = 0; i < n; i++)
         step(path[i], 1'b1, o, oe);
   endtask

   // Mode select goes high on the last bit so the shift state is left cleanly
   task automatic shift(input logic [127:0] din, input int n, output logic [127:0] dout,
      output logic oe_all);
      logic o, oe;
      dout = '0;
      oe_all = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], o, oe);
         dout[i] = o;
         oe_all = oe_all & oe;
      end
   endtask
endmodule

`default_nettype wire

// ### jtv_regs.vh
// Constants for the test access port: states, instruction codes, register sizes
`ifndef JTV_REGS_VH
`define JTV_REGS_VH

// Controller state codes (4 bits)
`define JTV_ST_RESET 4'h0
`define JTV_ST_IDLE 4'h1
`define JTV_ST_SEL_DR 4'h2
`define JTV_ST_CAP_DR 4'h3
`define JTV_ST_SHIFT_DR 4'h4
`define JTV_ST_EXIT1_DR 4'h5
`define JTV_ST_PAUSE_DR 4'h6
`define JTV_ST_EXIT2_DR 4'h7
`define JTV_ST_UPD_DR 4'h8
`define JTV_ST_SEL_IR 4'h9
`define JTV_ST_CAP_IR 4'ha
`define JTV_ST_SHIFT_IR 4'hb
`define JTV_ST_EXIT1_IR 4'hc
`define JTV_ST_PAUSE_IR 4'hd
`define JTV_ST_EXIT2_IR 4'he
`define JTV_ST_UPD_IR 4'hf

// Instruction register
`define JTV_IR_W 3
`define JTV_INS_EXTEST 3'h0
`define JTV_INS_IDCODE 3'h1
`define JTV_INS_SAMPLE_Z 3'h2
`define JTV_INS_SAMPLE 3'h4
`define JTV_INS_BYPASS 3'h7
`define JTV_IR_CAPTURE 2'h1

// Data register selection codes
`define JTV_SEL_BYP 2'h0
`define JTV_SEL_ID 2'h1
`define JTV_SEL_BSR 2'h2

// Identification word; value is arbitrary, bit 0 set as the standard demands
`define JTV_ID_W 32
`define JTV_ID_VALUE 32'h0a5c_3001

// Boundary register length and the output-bus enable cell
`define JTV_BSR_W 109
`define JTV_BSR_OE_BIT 108

// Reset values of the serial input synchronisers (pull-ups)
`define JTV_PIN_IDLE 1'h1
// Test clock rests low, so its synchroniser must reset low too
`define JTV_TCK_IDLE 1'h0

`endif

// ### jtv_sync.v
// Two-stage synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
`include "jtv_regs.vh"

module jtv_sync
#(
   parameter [0:0] IDLE = `JTV_PIN_IDLE
)
(
   input wire ref_clk,
   input wire rst_b,
   input wire din,
   output reg dout
);

   reg stage1;

   // Reset to the pin's resting level; any other value fakes an edge once reset ends
   always @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         stage1 <= IDLE;
         dout <= IDLE;
      end
      else
      begin
         stage1 <= din;
         dout <= stage1;
      end
   end

endmodule

`default_nettype wire

// ### jtv_tap.v
// Test access port of the memory: controller, instruction and data scan registers
// Summary of operation
// - Boundary scan after the standard, short of full conformance (latches update on rise), with the sixteen-state controller steered by mode select.
// - Inputs sampled on test-clock rise; serial output and enable updated on test-clock fall, instruction and boundary latch on rise.
// - Mode select sampled each rise and reads high when left undriven.
// - Current instruction picks the data register between serial in and out.
// - Serial input enters the selected register at its most significant bit.
// - Serial output shows selected LSB, driven only while shifting, changes on fall.
// - Five rising edges with mode select high reach the reset state.
// - Port reset leaves the memory function alone, even during accesses.
// - Power-up resets the port without clocking; serial output starts undriven.
// - With test clock held low the port stays reset and inert.
// - Exactly one scan register is in the serial path at any time.
// - Three-bit instruction register, shifted only while it is the serial path.
// - Power-up and the reset state load the identification instruction.
// - Capture-IR loads the two lowest instruction bits with 01.
// - Bypass is a one-bit register between serial in and out.
// - Bypass bit is cleared when the bypass instruction runs.
// - A shifted instruction takes effect only at Update-IR.
// - Identification register holds a fixed 32-bit code, captured then shifted.
`timescale 1ns/1ps
`default_nettype none
`include "jtv_regs.vh"

module jtv_tap
(
   input wire ref_clk,
   input wire rst_b,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire [`JTV_BSR_W-1:0] pin_ring,
   output reg tdo,
   output reg tdo_oe,
   output reg tap_in_reset,
   output reg [`JTV_IR_W-1:0] instr,
   output reg [`JTV_BSR_W-1:0] bsr_latch,
   output reg extest_drive,
   output reg out_bus_hiz
);

   // Data register picked by an instruction; reserved codes fall back to bypass
   function [1:0] dr_select;
      input [`JTV_IR_W-1:0] code;
      begin
         case (code)
            `JTV_INS_IDCODE: dr_select = `JTV_SEL_ID;
            `JTV_INS_EXTEST: dr_select = `JTV_SEL_BSR;
            `JTV_INS_SAMPLE: dr_select = `JTV_SEL_BSR;
            `JTV_INS_SAMPLE_Z: dr_select = `JTV_SEL_BSR;
            default: dr_select = `JTV_SEL_BYP;
         endcase
      end
   endfunction

   wire tck_s;
   wire tms_s;
   wire tdi_s;
   reg tck_d;
   wire tck_rise;
   wire tck_fall;
   reg [3:0] state;
   wire [3:0] next_state;
   reg [`JTV_IR_W-1:0] ir_shift;
   reg [`JTV_ID_W-1:0] id_shift;
   reg bypass_bit;
   reg [`JTV_BSR_W-1:0] bsr_shift;
   reg next_tdo;
   wire [1:0] sel;
   wire shifting;
   wire next_hiz;

   // TCK is only sampled here; the whole port runs on ref_clk so it needs no second domain
   jtv_sync
   #(
      .IDLE(`JTV_TCK_IDLE)
   )
   u_sync_tck
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .din(tck),
      .dout(tck_s)
   );

   jtv_sync u_sync_tms
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .din(tms),
      .dout(tms_s)
   );

   jtv_sync u_sync_tdi
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .din(tdi),
      .dout(tdi_s)
   );

   jtv_fsm u_fsm
   (
      .state(state),
      .tms(tms_s),
      .next_state(next_state)
   );

   // Reset value low: a TCK tied low never produces an edge, so the port stays reset
   always @(posedge ref_clk)
   begin
      if (!rst_b)
         tck_d <= 1'h0;
      else
         tck_d <= tck_s;
   end

   assign tck_rise = tck_s & ~tck_d;
   assign tck_fall = ~tck_s & tck_d;
   assign sel = dr_select(instr);
   assign shifting = (state == `JTV_ST_SHIFT_DR) || (state == `JTV_ST_SHIFT_IR);

   // Controller state advances on each sampled rising edge
   always @(posedge ref_clk)
   begin
      if (!rst_b)
         state <= `JTV_ST_RESET;
      else if (tck_rise)
         state <= next_state;
   end

   // Instruction register: shift, capture pattern, update, reset load
   always @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         ir_shift <= `JTV_INS_IDCODE;
         instr <= `JTV_INS_IDCODE;
      end
      else if (tck_rise)
      begin
         case (state)
            `JTV_ST_RESET:
            begin
               instr <= `JTV_INS_IDCODE;
            end
            `JTV_ST_CAP_IR:
            begin
               ir_shift <= {1'h0, `JTV_IR_CAPTURE};
            end
            `JTV_ST_SHIFT_IR:
            begin
               ir_shift <= {tdi_s, ir_shift[`JTV_IR_W-1:1]};
            end
            `JTV_ST_UPD_IR:
            begin
               instr <= ir_shift;
            end
            default:
            begin
               instr <= instr;
            end
         endcase
         // Load at the rise that enters reset, not one test clock later
         if (next_state == `JTV_ST_RESET)
            instr <= `JTV_INS_IDCODE;
      end
   end

   // Data registers: only the selected one captures and shifts
   always @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         id_shift <= `JTV_ID_VALUE;
         bypass_bit <= 1'h0;
         bsr_shift <= {`JTV_BSR_W{1'h0}};
      end
      else if (tck_rise && state == `JTV_ST_CAP_DR)
      begin
         if (sel == `JTV_SEL_ID)
            id_shift <= `JTV_ID_VALUE;
         if (sel == `JTV_SEL_BYP)
            bypass_bit <= 1'h0;
         if (sel == `JTV_SEL_BSR)
            bsr_shift <= pin_ring;
      end
      else if (tck_rise && state == `JTV_ST_SHIFT_DR)
      begin
         if (sel == `JTV_SEL_ID)
            id_shift <= {tdi_s, id_shift[`JTV_ID_W-1:1]};
         if (sel == `JTV_SEL_BYP)
            bypass_bit <= tdi_s;
         if (sel == `JTV_SEL_BSR)
            bsr_shift <= {tdi_s, bsr_shift[`JTV_BSR_W-1:1]};
      end
   end

   // Parallel latch of the boundary cells; the output-enable cell presets high
   always @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         bsr_latch <= {`JTV_BSR_W{1'h0}};
         bsr_latch[`JTV_BSR_OE_BIT] <= 1'h1;
      end
      else if (tck_rise)
      begin
         if (next_state == `JTV_ST_RESET)
            bsr_latch[`JTV_BSR_OE_BIT] <= 1'h1;
         else if (state == `JTV_ST_UPD_DR && sel == `JTV_SEL_BSR
                  && instr != `JTV_INS_SAMPLE_Z)
            bsr_latch <= bsr_shift;
      end
   end

   // Serial output source, LSB of whichever register is in the path
   always @*
   begin
      next_tdo = bypass_bit;
      if (state == `JTV_ST_SHIFT_IR)
         next_tdo = ir_shift[0];
      else if (sel == `JTV_SEL_ID)
         next_tdo = id_shift[0];
      else if (sel == `JTV_SEL_BSR)
         next_tdo = bsr_shift[0];
   end

   // Output bus goes high Z under SAMPLE Z, or under EXTEST with the enable cell low
   assign next_hiz = (instr == `JTV_INS_SAMPLE_Z)
                     || (instr == `JTV_INS_EXTEST && !bsr_latch[`JTV_BSR_OE_BIT]);

   // Test outputs change only on the sampled falling edge
   always @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         tdo <= 1'h0;
         tdo_oe <= 1'h0;
      end
      else if (tck_fall)
      begin
         tdo <= next_tdo;
         tdo_oe <= shifting;
      end
   end

   // Status to the memory core; the core never sees a reset from here
   always @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         tap_in_reset <= 1'h1;
         extest_drive <= 1'h0;
         out_bus_hiz <= 1'h0;
      end
      else
      begin
         tap_in_reset <= (state == `JTV_ST_RESET);
         extest_drive <= (instr == `JTV_INS_EXTEST);
         out_bus_hiz <= next_hiz;
      end
   end

endmodule

`default_nettype wire

// ### jtv_tap_chk.sv
// Timing and selection checks on the test port pins
`timescale 1ns/1ps
`default_nettype none
`include "jtv_regs.vh"

module jtv_tap_chk
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic tap_in_reset,
   input wire logic [`JTV_IR_W-1:0] instr,
   input wire logic out_bus_hiz,
   input wire logic extest_drive
);
   logic tck_q;
   logic [7:0] since_rise;
   logic [7:0] since_fall;
   logic [2:0] ones;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // Counters saturate so a long idle span never wraps back into a window
   always @(posedge ref_clk)
   begin
      tck_q <= tck;
      if (!rst_b)
      begin
         since_rise <= 8'hff;
         since_fall <= 8'hff;
         ones <= 3'h0;
      end
      else
      begin
         since_rise <= (tck && !tck_q) ? 8'h00 : since_rise + {7'h0, since_rise != 8'hff};
         since_fall <= (!tck && tck_q) ? 8'h00 : since_fall + {7'h0, since_fall != 8'hff};
         if (tck && !tck_q)
            ones <= tms ? ones + {2'h0, ones != 3'h5} : 3'h0;
      end
   end

   sequence s_hiz_held;
      (instr == `JTV_INS_SAMPLE_Z) [*3];
   endsequence

   a_tdo_fall: assert property ($changed(tdo) |-> since_fall inside {[1:6]})
      else $error("serial out moved away from a clock fall");
   a_oe_fall: assert property ($changed(tdo_oe) |-> since_fall inside {[1:6]})
      else $error("output enable moved away from a clock fall");
   a_instr_rise: assert property ($changed(instr) |-> since_rise inside {[1:6]})
      else $error("instruction moved away from a clock rise");
   a_oe_reset: assert property (tap_in_reset |-> !tdo_oe)
      else $error("serial out driven in reset state");
   a_reset_id: assert property (tap_in_reset [*3] |-> instr == `JTV_INS_IDCODE)
      else $error("reset state without id instruction");
   a_quiet_idle: assert property (!tck && since_fall > 8'h08
      |-> $stable(instr) && $stable(tdo_oe) && $stable(tdo))
      else $error("port changed with clock held low");
   a_five_ones: assert property (ones == 3'h5 && since_rise == 8'h08 |-> tap_in_reset)
      else $error("five high rises did not reset");
   a_extest_sel: assert property ($stable(instr) [*3]
      |-> extest_drive == (instr == `JTV_INS_EXTEST))
      else $error("drive flag disagrees with instruction");
   a_hiz_sel: assert property (s_hiz_held |-> out_bus_hiz && !extest_drive)
      else $error("output bus not floated");
endmodule

bind jtv_tap jtv_tap_chk chk
(
   .ref_clk(ref_clk),
   .rst_b(rst_b),
   .tck(tck),
   .tms(tms),
   .tdo(tdo),
   .tdo_oe(tdo_oe),
   .tap_in_reset(tap_in_reset),
   .instr(instr),
   .out_bus_hiz(out_bus_hiz),
   .extest_drive(extest_drive)
);

`default_nettype wire

// ### tb.sv
// Self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
`include "jtv_regs.vh"

module tb;
   logic ref_clk, rst_b, tck, tms, tdi, tdo, tdo_oe, tap_in_reset, extest_drive, out_bus_hiz;
   logic [`JTV_IR_W-1:0] instr;
   logic [`JTV_BSR_W-1:0] pin_ring, bsr_latch;
   logic [127:0] d;
   int failures, check_count;

   jtv_tap dut(.ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
      .pin_ring(pin_ring), .tdo(tdo), .tdo_oe(tdo_oe), .tap_in_reset(tap_in_reset),
      .instr(instr), .bsr_latch(bsr_latch), .extest_drive(extest_drive),
      .out_bus_hiz(out_bus_hiz));
   jtv_host host(.ref_clk(ref_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
      .tdi(tdi));

   always #2.5 ref_clk = ~ref_clk;

   task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // From Idle through Shift-IR and back to Idle
   task automatic ir_load(input logic [2:0] code);
      logic [2:0] old;
      logic oe;
      old = instr;
      host.walk(8'h03, 4);
      host.shift({125'h0, code}, 3, d, oe);
      check(d[2:0], 3'h1, "ir capture");
      check(instr, old, "ir early");
      host.walk(8'h01, 2);
      check(instr, code, "ir update");
   endtask

   task automatic dr(input logic [127:0] din, input int n);
      logic oe;
      host.walk(8'h01, 3);
      host.shift(din, n, d, oe);
      check(oe, 1'b1, "oe in shift");
      host.walk(8'h01, 2);
      check(tdo_oe, 1'b0, "oe after shift");
   endtask

   task automatic t_power();
      check({tap_in_reset, instr, tdo_oe}, 5'h12, "power up");
      check(bsr_latch, {1'b1, 108'h0}, "latch preset");
      host.walk(8'h00, 1);
      dr(128'h0, 32);
      check(d[31:0], `JTV_ID_VALUE, "id word");
   endtask

   task automatic t_byp();
      logic [2:0] codes [3] = '{3'h3, 3'h5, 3'h6};
      ir_load(`JTV_INS_BYPASS);
      dr(128'hb5, 8);
      check(d[7:0], 8'h6a, "bypass");
      foreach (codes[i])
      begin
         ir_load(codes[i]);
         dr(128'hb5, 8);
         check(d[7:0], 8'h6a, "unused code");
      end
   endtask

   task automatic t_bsr();
      pin_ring <= {1'b1, {27{4'h9}}};
      ir_load(`JTV_INS_SAMPLE);
      dr({20'h0, {27{4'h6}}}, 109);
      check(d[108:0], pin_ring, "capture");
      check(bsr_latch, {1'b0, {27{4'h6}}}, "latch");
      ir_load(`JTV_INS_EXTEST);
      check({extest_drive, out_bus_hiz}, 2'h3, "extest");
      ir_load(`JTV_INS_SAMPLE_Z);
      check({extest_drive, out_bus_hiz}, 2'h1, "float");
   endtask

   // Into Shift-DR, then four high rises must not reset but the fifth must
   task automatic t_reset5();
      host.walk(8'h79, 7);
      check({tap_in_reset, instr}, 4'h2, "four highs");
      host.walk(8'h01, 1);
      check({tap_in_reset, instr, bsr_latch[108]}, 5'h13, "five highs");
      host.walk(8'h00, 1);
      ir_load(`JTV_INS_EXTEST);
      check({extest_drive, out_bus_hiz}, 2'h2, "extest drive");
   endtask

   initial
   begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      pin_ring = '0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (50) @(posedge ref_clk);
      t_power();
      t_byp();
      t_bsr();
      t_reset5();
      summarize();
   end

   // The run needs about 9200 cycles
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      failures++;
      summarize();
   end
endmodule

`default_nettype wire
